/* inc/hpkm_pkg.sv */
// Shared constants for the keyboard-reader command handler.
package hpkm_pkg;
  // Report layout.
  localparam int           RPT_LEN        = 24;
  localparam int           DATA_MAX       = 22;
  localparam int           OFS_CMD        = 0;
  localparam int           OFS_LEN        = 1;
  localparam int           OFS_DATA       = 2;
  // Command numbers.
  localparam logic [7:0]   CMD_GET_PROP   = 8'h00;
  localparam logic [7:0]   CMD_SET_PROP   = 8'h01;
  localparam logic [7:0]   CMD_RESET      = 8'h02;
  localparam logic [7:0]   CMD_GET_KEY    = 8'h03;
  localparam logic [7:0]   CMD_SET_KEY    = 8'h04;
  // Generic result codes.
  localparam logic [7:0]   RES_SUCCESS    = 8'h00;
  localparam logic [7:0]   RES_FAILURE    = 8'h01;
  localparam logic [7:0]   RES_BAD_PARAM  = 8'h02;
  // Property identifiers, sizes and reset values.
  localparam logic [7:0]   PROP_SW_ID     = 8'h00;
  localparam logic [7:0]   PROP_SERIAL    = 8'h01;
  localparam logic [7:0]   PROP_POLL      = 8'h02;
  localparam logic [7:0]   PROP_FLAGS     = 8'h04;
  localparam logic [7:0]   PROP_CONV      = 8'h0f;
  localparam logic [7:0]   PROP_MAP_SEL   = 8'h11;
  localparam int           SW_ID_LEN      = 11;
  localparam int           SERIAL_MAX     = 15;
  localparam logic [7:0]   POLL_RST       = 8'h01;
  localparam logic [7:0]   FLAGS_RST      = 8'h00;
  localparam logic [7:0]   CONV_RST       = 8'h00;
  localparam logic [7:0]   MAP_SEL_RST    = 8'h00;
  // Key map.
  localparam int           MAP_ENTRIES    = 128;
  localparam logic [7:0]   ASCII_MAX      = 8'h7f;
  localparam logic [7:0]   ALT_MARK       = 8'hff;
  localparam logic [7:0]   MOD_LEFT_ALT   = 8'h04;
  localparam logic [7:0]   KP_ZERO        = 8'h62;
  localparam logic [7:0]   KP_ONE         = 8'h59;
  // Timing of the detach that the reset command performs.
  localparam int           CLK_HZ         = 25_000_000;
  localparam int           DETACH_TIME_MS = 10;
  localparam int           DETACH_CYCLES  = DETACH_TIME_MS * (CLK_HZ / 1000);
endpackage : hpkm_pkg

/* hw/hpkm_cmd.sv */
// Command handler for property, reset and key map commands, with keystroke output.
`timescale 1ns/1ps

// What this block does
// - Property command reloads stored legacy settings when legacy_dirty_i is set.
// - Get property: id in, value bytes out.
// - Set property: id plus value, no data.
// - Property commands use generic result codes only.
// - Byte is one byte; strings unterminated.
// - Command 2 resets, result zero.
// - Reset makes changed properties take effect.
// - Reset detaches then reattaches to host.
// - Command 3 reads entry for ASCII 0-127.
// - Key read returns usage then modifier.
// - Each character sent as mapped keystroke.
// - FF/FF entry sends ALT keypad decimal digits.
// - Command 4 writes ASCII, usage, modifier entry.
// - Written entry acts now, lost on reset.
// - Report: command, length, 22 data bytes.
// - Results: 0 success, 1 failure, 2 bad.
// - Status stage held until command done.
module hpkm_cmd #(
  parameter int           DETACH_CYC = hpkm_pkg::DETACH_CYCLES,
  // Arbitrary software identification string.
  parameter logic [87:0]  SW_ID      = 88'h4e_45_55_54_52_41_4c_30_30_30_31
) (
  // Clock and reset.
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  // Feature report data stage and completion.
  input  wire logic       req_wr_i,
  input  wire logic [4:0] req_idx_i,
  input  wire logic [7:0] req_byte_i,
  input  wire logic       req_done_i,
  output logic            cmd_busy_o,
  // Response report read port.
  input  wire logic [4:0] rsp_idx_i,
  output logic [7:0]      rsp_byte_o,
  // Legacy settings and enumeration control.
  input  wire logic       legacy_dirty_i,
  output logic            legacy_reload_o,
  output logic            usb_detach_o,
  output logic            prop_apply_o,
  output logic [7:0]      cfg_poll_o,
  output logic [7:0]      cfg_flags_o,
  output logic [7:0]      cfg_conv_o,
  output logic [7:0]      cfg_map_sel_o,
  // Character stream in, keystrokes out.
  input  wire logic       char_valid_i,
  input  wire logic [6:0] char_i,
  output logic            char_ready_o,
  output logic            key_valid_o,
  output logic [7:0]      key_usage_o,
  output logic [7:0]      key_mod_o,
  input  wire logic       key_ready_i
);
  import hpkm_pkg::*;

  localparam int CW = $clog2(DETACH_CYC + 1);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_EXEC   = 3'b010,
    ST_DETACH = 3'b100
  } hpkm_st_e;

  typedef enum logic [1:0] {
    K_IDLE = 2'b01,
    K_SEND = 2'b10
  } hpkm_kst_e;

  function automatic logic [3:0] dec_digit(input logic [6:0] c, input logic [1:0] pos);
    logic [7:0] v;
    v = {1'b0, c};
    case (pos)
      2'd2:    dec_digit = 4'(v / 8'd100);
      2'd1:    dec_digit = 4'((v / 8'd10) % 8'd10);
      default: dec_digit = 4'(v % 8'd10);
    endcase
  endfunction : dec_digit

  function automatic logic [7:0] kp_usage(input logic [3:0] d);
    kp_usage = (d == 4'h0) ? KP_ZERO : 8'(KP_ONE + {4'h0, d} - 8'h01);
  endfunction : kp_usage

  // Command state.
  hpkm_st_e        st_ff, nxt_st;
  logic [CW-1:0]   cnt_ff, nxt_cnt;
  logic [7:0]      req_ff [RPT_LEN];
  logic [7:0]      rsp_ff [RPT_LEN], nxt_rsp [RPT_LEN];
  logic [7:0]      serial_ff [SERIAL_MAX], nxt_serial [SERIAL_MAX];
  logic [7:0]      ser_len_ff, nxt_ser_len;
  logic [7:0]      poll_ff, nxt_poll, flags_ff, nxt_flags, conv_ff, nxt_conv;
  logic [7:0]      map_sel_ff, nxt_map_sel;
  logic [7:0]      km_use_ff [MAP_ENTRIES], nxt_km_use [MAP_ENTRIES];
  logic [7:0]      km_mod_ff [MAP_ENTRIES], nxt_km_mod [MAP_ENTRIES];
  logic            busy_ff, nxt_busy, reload_ff, nxt_reload;
  logic            detach_ff, nxt_detach, apply_ff, nxt_apply;
  logic [7:0]      cfg_poll_ff, cfg_flags_ff, cfg_conv_ff, cfg_map_ff;
  logic [7:0]      rsp_out_ff;
  logic [7:0]      cmd, dlen, pid, vlen;
  logic [6:0]      kidx;
  logic            is_prop;

  assign cmd     = req_ff[OFS_CMD];
  assign dlen    = req_ff[OFS_LEN];
  assign pid     = req_ff[OFS_DATA];
  assign vlen    = dlen - 8'h01;
  assign kidx    = req_ff[OFS_DATA][6:0];
  assign is_prop = (cmd == CMD_GET_PROP) || (cmd == CMD_SET_PROP);

  always_comb begin
    nxt_st      = st_ff;
    nxt_cnt     = cnt_ff;
    nxt_rsp     = rsp_ff;
    nxt_serial  = serial_ff;
    nxt_ser_len = ser_len_ff;
    nxt_poll    = poll_ff;
    nxt_flags   = flags_ff;
    nxt_conv    = conv_ff;
    nxt_map_sel = map_sel_ff;
    nxt_km_use  = km_use_ff;
    nxt_km_mod  = km_mod_ff;
    nxt_busy    = busy_ff;
    nxt_reload  = 1'b0;
    nxt_detach  = detach_ff;
    nxt_apply   = 1'b0;
    unique case (st_ff)
      ST_IDLE: begin
        if (req_done_i) begin
          nxt_st   = ST_EXEC;
          nxt_busy = 1'b1;
        end
      end
      ST_EXEC: begin
        nxt_busy = 1'b0;
        for (int i = 0; i < RPT_LEN; i++) begin
          nxt_rsp[i] = 8'h00;
        end
        nxt_rsp[OFS_CMD] = RES_SUCCESS;
        nxt_st           = ST_IDLE;
        if (is_prop && legacy_dirty_i) begin
          nxt_reload = 1'b1;
        end
        if (dlen > 8'(DATA_MAX)) begin
          nxt_rsp[OFS_CMD] = RES_BAD_PARAM;
        end else if (cmd == CMD_GET_PROP) begin
          nxt_rsp[OFS_LEN] = 8'h01;
          unique case (pid)
            PROP_SW_ID: begin
              nxt_rsp[OFS_LEN] = 8'(SW_ID_LEN);
              for (int i = 0; i < SW_ID_LEN; i++) begin
                nxt_rsp[OFS_DATA + i] = SW_ID[8 * (SW_ID_LEN - 1 - i) +: 8];
              end
            end
            PROP_SERIAL: begin
              nxt_rsp[OFS_LEN] = ser_len_ff;
              for (int i = 0; i < SERIAL_MAX; i++) begin
                nxt_rsp[OFS_DATA + i] = serial_ff[i];
              end
            end
            PROP_POLL:    nxt_rsp[OFS_DATA] = poll_ff;
            PROP_FLAGS:   nxt_rsp[OFS_DATA] = flags_ff;
            PROP_CONV:    nxt_rsp[OFS_DATA] = conv_ff;
            PROP_MAP_SEL: nxt_rsp[OFS_DATA] = map_sel_ff;
            default: begin
              nxt_rsp[OFS_LEN] = 8'h00;
              nxt_rsp[OFS_CMD] = RES_BAD_PARAM;
            end
          endcase
        end else if (cmd == CMD_SET_PROP) begin
          if (dlen == 8'h00) begin
            nxt_rsp[OFS_CMD] = RES_BAD_PARAM;
          end else if (pid == PROP_SW_ID) begin
            nxt_rsp[OFS_CMD] = RES_FAILURE;
          end else if (pid == PROP_SERIAL) begin
            if (vlen > 8'(SERIAL_MAX)) begin
              nxt_rsp[OFS_CMD] = RES_BAD_PARAM;
            end else begin
              nxt_ser_len = vlen;
              for (int i = 0; i < SERIAL_MAX; i++) begin
                nxt_serial[i] = (8'(i) < vlen) ? req_ff[OFS_DATA + 1 + i] : 8'h00;
              end
            end
          end else if (vlen != 8'h01) begin
            nxt_rsp[OFS_CMD] = RES_BAD_PARAM;
          end else begin
            unique case (pid)
              PROP_POLL: begin
                if (req_ff[OFS_DATA + 1] == 8'h00) begin
                  nxt_rsp[OFS_CMD] = RES_BAD_PARAM;
                end else begin
                  nxt_poll = req_ff[OFS_DATA + 1];
                end
              end
              PROP_FLAGS:   nxt_flags   = req_ff[OFS_DATA + 1];
              PROP_CONV:    nxt_conv    = req_ff[OFS_DATA + 1];
              PROP_MAP_SEL: nxt_map_sel = req_ff[OFS_DATA + 1];
              default:      nxt_rsp[OFS_CMD] = RES_BAD_PARAM;
            endcase
          end
        end else if (cmd == CMD_RESET) begin
          nxt_st     = ST_DETACH;
          nxt_cnt    = CW'(DETACH_CYC - 1);
          nxt_detach = 1'b1;
        end else if (cmd == CMD_GET_KEY) begin
          if (pid > ASCII_MAX) begin
            nxt_rsp[OFS_CMD] = RES_BAD_PARAM;
          end else begin
            nxt_rsp[OFS_LEN]      = 8'h02;
            nxt_rsp[OFS_DATA]     = km_use_ff[kidx];
            nxt_rsp[OFS_DATA + 1] = km_mod_ff[kidx];
          end
        end else if (cmd == CMD_SET_KEY) begin
          if (pid > ASCII_MAX) begin
            nxt_rsp[OFS_CMD] = RES_BAD_PARAM;
          end else begin
            nxt_km_use[kidx] = req_ff[OFS_DATA + 1];
            nxt_km_mod[kidx] = req_ff[OFS_DATA + 2];
          end
        end else begin
          nxt_rsp[OFS_CMD] = RES_FAILURE;
        end
      end
      ST_DETACH: begin
        nxt_cnt = cnt_ff - CW'(1);
        if (cnt_ff == '0) begin
          nxt_st     = ST_IDLE;
          nxt_detach = 1'b0;
          nxt_apply  = 1'b1;
          for (int i = 0; i < MAP_ENTRIES; i++) begin
            nxt_km_use[i] = ALT_MARK;
            nxt_km_mod[i] = ALT_MARK;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_ff      <= ST_IDLE;
      cnt_ff     <= '0;
      ser_len_ff <= 8'h00;
      poll_ff    <= POLL_RST;
      flags_ff   <= FLAGS_RST;
      conv_ff    <= CONV_RST;
      map_sel_ff <= MAP_SEL_RST;
      busy_ff    <= 1'b0;
      reload_ff  <= 1'b0;
      detach_ff  <= 1'b0;
      apply_ff   <= 1'b0;
      for (int i = 0; i < RPT_LEN; i++) begin
        req_ff[i] <= 8'h00;
        rsp_ff[i] <= 8'h00;
      end
      for (int i = 0; i < SERIAL_MAX; i++) begin
        serial_ff[i] <= 8'h00;
      end
      for (int i = 0; i < MAP_ENTRIES; i++) begin
        km_use_ff[i] <= ALT_MARK;
        km_mod_ff[i] <= ALT_MARK;
      end
    end else begin
      st_ff      <= nxt_st;
      cnt_ff     <= nxt_cnt;
      rsp_ff     <= nxt_rsp;
      serial_ff  <= nxt_serial;
      ser_len_ff <= nxt_ser_len;
      poll_ff    <= nxt_poll;
      flags_ff   <= nxt_flags;
      conv_ff    <= nxt_conv;
      map_sel_ff <= nxt_map_sel;
      km_use_ff  <= nxt_km_use;
      km_mod_ff  <= nxt_km_mod;
      busy_ff    <= nxt_busy;
      reload_ff  <= nxt_reload;
      detach_ff  <= nxt_detach;
      apply_ff   <= nxt_apply;
      if (req_wr_i && (int'(req_idx_i) < RPT_LEN)) begin
        req_ff[req_idx_i] <= req_byte_i;
      end
    end
  end

  // Applied configuration and response read port.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cfg_poll_ff  <= POLL_RST;
      cfg_flags_ff <= FLAGS_RST;
      cfg_conv_ff  <= CONV_RST;
      cfg_map_ff   <= MAP_SEL_RST;
      rsp_out_ff   <= 8'h00;
    end else begin
      if (apply_ff) begin
        cfg_poll_ff  <= poll_ff;
        cfg_flags_ff <= flags_ff;
        cfg_conv_ff  <= conv_ff;
        cfg_map_ff   <= map_sel_ff;
      end
      rsp_out_ff <= (int'(rsp_idx_i) < RPT_LEN) ? rsp_ff[rsp_idx_i] : 8'h00;
    end
  end

  // Keystroke emitter.
  hpkm_kst_e   kst_ff, nxt_kst;
  logic        crdy_ff, nxt_crdy, kval_ff, nxt_kval;
  logic [7:0]  kuse_ff, nxt_kuse, kmod_ff, nxt_kmod;
  logic [6:0]  ch_ff, nxt_ch;
  logic [1:0]  left_ff, nxt_left;
  logic [7:0]  look_use, look_mod;
  logic        take, alt_code;

  assign look_use = km_use_ff[char_i];
  assign look_mod = km_mod_ff[char_i];
  assign take     = char_valid_i && crdy_ff;
  assign alt_code = (look_use == ALT_MARK) && (look_mod == ALT_MARK);

  always_comb begin
    nxt_kst  = kst_ff;
    nxt_crdy = crdy_ff;
    nxt_kval = kval_ff;
    nxt_kuse = kuse_ff;
    nxt_kmod = kmod_ff;
    nxt_ch   = ch_ff;
    nxt_left = left_ff;
    unique case (kst_ff)
      K_IDLE: begin
        if (take) begin
          nxt_kst  = K_SEND;
          nxt_crdy = 1'b0;
          nxt_kval = 1'b1;
          nxt_ch   = char_i;
          if (alt_code) begin
            nxt_kuse = kp_usage(dec_digit(char_i, 2'd2));
            nxt_kmod = MOD_LEFT_ALT;
            nxt_left = 2'd2;
          end else begin
            nxt_kuse = look_use;
            nxt_kmod = look_mod;
            nxt_left = 2'd0;
          end
        end
      end
      K_SEND: begin
        if (key_ready_i) begin
          if (left_ff == 2'd0) begin
            nxt_kst  = K_IDLE;
            nxt_kval = 1'b0;
            nxt_crdy = 1'b1;
          end else begin
            nxt_kuse = kp_usage(dec_digit(ch_ff, left_ff - 2'd1));
            nxt_left = left_ff - 2'd1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      kst_ff  <= K_IDLE;
      crdy_ff <= 1'b1;
      kval_ff <= 1'b0;
      kuse_ff <= 8'h00;
      kmod_ff <= 8'h00;
      ch_ff   <= 7'h00;
      left_ff <= 2'd0;
    end else begin
      kst_ff  <= nxt_kst;
      crdy_ff <= nxt_crdy;
      kval_ff <= nxt_kval;
      kuse_ff <= nxt_kuse;
      kmod_ff <= nxt_kmod;
      ch_ff   <= nxt_ch;
      left_ff <= nxt_left;
    end
  end

  assign cmd_busy_o      = busy_ff;
  assign rsp_byte_o      = rsp_out_ff;
  assign legacy_reload_o = reload_ff;
  assign usb_detach_o    = detach_ff;
  assign prop_apply_o    = apply_ff;
  assign cfg_poll_o      = cfg_poll_ff;
  assign cfg_flags_o     = cfg_flags_ff;
  assign cfg_conv_o      = cfg_conv_ff;
  assign cfg_map_sel_o   = cfg_map_ff;
  assign char_ready_o    = crdy_ff;
  assign key_valid_o     = kval_ff;
  assign key_usage_o     = kuse_ff;
  assign key_mod_o       = kmod_ff;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_status_held: assert property (
    (st_ff == ST_IDLE && req_done_i) |=> cmd_busy_o ##1 !cmd_busy_o)
    else $error("status stage not released one cycle after execution");
  a_reset_result: assert property (
    (st_ff == ST_EXEC && cmd == CMD_RESET && dlen <= 8'(DATA_MAX))
    |=> rsp_ff[0] == RES_SUCCESS && usb_detach_o)
    else $error("reset command did not answer success and detach");
  a_detach_ends: assert property (
    (usb_detach_o && st_ff == ST_DETACH && cnt_ff == '0) |=> !usb_detach_o && prop_apply_o)
    else $error("detach did not end in reattach and apply");
  a_legacy_reload: assert property (
    (st_ff == ST_EXEC && is_prop && legacy_dirty_i) |=> legacy_reload_o)
    else $error("legacy reload missing on property command");
  a_prop_generic: assert property (
    (st_ff == ST_EXEC && is_prop) |=> rsp_ff[0] <= RES_BAD_PARAM)
    else $error("property command gave a non-generic result");
  a_key_bad_ascii: assert property (
    (st_ff == ST_EXEC && cmd == CMD_GET_KEY && pid > ASCII_MAX) |=> rsp_ff[0] == RES_BAD_PARAM)
    else $error("out-of-range ASCII not refused");
  a_key_write_now: assert property (
    (st_ff == ST_EXEC && cmd == CMD_SET_KEY && pid <= ASCII_MAX && dlen <= 8'd22)
    |=> km_use_ff[$past(kidx)] == $past(req_ff[3]))
    else $error("key map write not visible at once");
  a_alt_digit: assert property (
    (kst_ff == K_IDLE && take && alt_code) |=> key_valid_o && key_mod_o == MOD_LEFT_ALT
    && left_ff == 2'd2)
    else $error("ALT fallback did not start with left ALT digit");
  a_mapped_key: assert property (
    (kst_ff == K_IDLE && take && !alt_code) |=> key_valid_o && key_usage_o == $past(look_use))
    else $error("mapped keystroke does not match the map");
endmodule : hpkm_cmd

/* sim/hpkm_host.sv */
// Host model that sends command reports and fetches their responses.
`timescale 1ns/1ps

module hpkm_host (
  // Clock.
  input  wire logic       sys_clk_i,
  // Request side of the handler.
  output logic            req_wr_o,
  output logic [4:0]      req_idx_o,
  output logic [7:0]      req_byte_o,
  output logic            req_done_o,
  input  wire logic       cmd_busy_i,
  // Response side and bus state.
  output logic [4:0]      rsp_idx_o,
  input  wire logic [7:0] rsp_byte_i,
  input  wire logic       usb_detach_i
);
  logic [7:0] rsp_q [24];
  bit         busy_ok;

  initial begin
    req_wr_o   = 1'b0;
    req_idx_o  = 5'h00;
    req_byte_o = 8'h00;
    req_done_o = 1'b0;
    rsp_idx_o  = 5'h00;
  end

  // Sends a whole report, waits out the busy status, then reads all 24 response bytes.
  task automatic xfer(input logic [7:0] rq [24]);
    int i;
    busy_ok = 0;
    for (i = 0; i < 24; i++) begin
      @(negedge sys_clk_i);
      req_wr_o   = 1'b1;
      req_idx_o  = i[4:0];
      req_byte_o = rq[i];
    end
    @(negedge sys_clk_i);
    req_wr_o   = 1'b0;
    req_done_o = 1'b1;
    @(negedge sys_clk_i);
    req_done_o = 1'b0;
    for (i = 0; i < 8 && !(busy_ok && cmd_busy_i === 1'b0); i++) begin
      busy_ok |= (cmd_busy_i === 1'b1);
      @(negedge sys_clk_i);
    end
    for (i = 0; i <= 24; i++) begin
      if (i > 0) rsp_q[i-1] = rsp_byte_i;
      if (i < 24) rsp_idx_o = i[4:0];
      @(negedge sys_clk_i);
    end
    // A reset command detaches; wait for the attach before talking again.
    for (i = 0; i < 64 && usb_detach_i !== 1'b0; i++)
      @(negedge sys_clk_i);
    repeat (2) @(negedge sys_clk_i);
  endtask : xfer
endmodule : hpkm_host

/* sim/tb.sv */
// Self-checking bench for the command handler and its keystroke path.
`timescale 1ns/1ps

module tb;
  import hpkm_pkg::*;
  localparam int          DCYC = 8;
  // Arbitrary identification text.
  localparam logic [87:0] SWID = 88'h42_45_4e_43_48_5f_49_44_2d_30_31;
  logic sys_clk_i, sys_rst_i, req_wr_i, req_done_i, cmd_busy_o, legacy_dirty_i;
  logic legacy_reload_o, usb_detach_o, prop_apply_o, char_valid_i, char_ready_o;
  logic key_valid_o, key_ready_i;
  logic [4:0] req_idx_i, rsp_idx_i;
  logic [6:0] char_i;
  logic [7:0] req_byte_i, rsp_byte_o, key_usage_o, key_mod_o;
  logic [7:0] cfg_poll_o, cfg_flags_o, cfg_conv_o, cfg_map_sel_o;
  logic [7:0] rq [24];
  logic [15:0] got_q [$];
  int exp_q [$];
  int er [24];
  int m_use [128];
  int m_mod [128];
  int pv [256];
  int ser [16];
  int ser_len, failures, cmp_count, reload_n, detach_n, apply_n, n0, a0, i, v;
  int seed;

  hpkm_cmd #(.DETACH_CYC(DCYC), .SW_ID(SWID)) dut_u (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_wr_i(req_wr_i),
    .req_idx_i(req_idx_i), .req_byte_i(req_byte_i), .req_done_i(req_done_i),
    .cmd_busy_o(cmd_busy_o), .rsp_idx_i(rsp_idx_i), .rsp_byte_o(rsp_byte_o),
    .legacy_dirty_i(legacy_dirty_i), .legacy_reload_o(legacy_reload_o),
    .usb_detach_o(usb_detach_o), .prop_apply_o(prop_apply_o), .cfg_poll_o(cfg_poll_o),
    .cfg_flags_o(cfg_flags_o), .cfg_conv_o(cfg_conv_o), .cfg_map_sel_o(cfg_map_sel_o),
    .char_valid_i(char_valid_i), .char_i(char_i), .char_ready_o(char_ready_o),
    .key_valid_o(key_valid_o), .key_usage_o(key_usage_o), .key_mod_o(key_mod_o),
    .key_ready_i(key_ready_i));

  hpkm_host host_u (
    .sys_clk_i(sys_clk_i), .req_wr_o(req_wr_i), .req_idx_o(req_idx_i),
    .req_byte_o(req_byte_i), .req_done_o(req_done_i), .cmd_busy_i(cmd_busy_o),
    .rsp_idx_o(rsp_idx_i), .rsp_byte_i(rsp_byte_o), .usb_detach_i(usb_detach_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (key_valid_o === 1'b1 && key_ready_i === 1'b1) got_q.push_back({key_usage_o, key_mod_o});
    reload_n += (legacy_reload_o === 1'b1);
    detach_n += (usb_detach_o === 1'b1);
    apply_n  += (prop_apply_o === 1'b1);
  end

  // The keystroke consumer stalls at random.
  always @(negedge sys_clk_i) key_ready_i <= ($random(seed) % 4) != 0;

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input int exp, input logic [15:0] got);
    cmp_count++;
    if (got !== 16'(exp)) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, 16'(exp), got);
    end
  endtask : chk

  // Reference behaviour of one command: updates model state and fills er.
  function automatic void model();
    int c, n, id, k;
    c = rq[0];
    n = rq[1];
    id = rq[2];
    v = rq[3];
    er = '{default: 0};
    if (n > DATA_MAX) er[0] = 2;
    else if (c == 2) begin
      for (k = 0; k < 128; k++) m_use[k] = 255;
      for (k = 0; k < 128; k++) m_mod[k] = 255;
    end else if (c == 3 || c == 4) begin
      if (id > 127) er[0] = 2;
      else if (c == 4) begin
        m_use[id] = v;
        m_mod[id] = rq[4];
      end else begin
        er[1] = 2;
        er[2] = m_use[id];
        er[3] = m_mod[id];
      end
    end else if (c > 1) er[0] = 1;
    else if (id == 0) begin
      er[0] = c;
      er[1] = (c == 0) ? 11 : 0;
      for (k = 0; k < er[1]; k++) er[2+k] = SWID[87-8*k -: 8];
    end else if (id == 1) begin
      if (c == 0) er[1] = ser_len;
      for (k = 0; k < ser_len && c == 0; k++) er[2+k] = ser[k];
      if (c == 1 && n > 16) er[0] = 2;
      else if (c == 1) ser_len = n - 1;
      for (k = 0; k < ser_len && c == 1 && n < 17; k++) ser[k] = rq[3+k];
    end else if (id inside {2, 4, 15, 17}) begin
      if (c == 0) er[1] = 1;
      if (c == 0) er[2] = pv[id];
      else if (n != 2 || (id == 2 && v == 0)) er[0] = 2;
      else pv[id] = v;
    end else er[0] = 2;
  endfunction : model

  task automatic cmd(input int c, input int n, input int d0, input int d1 = 0, input int d2 = 0);
    int k;
    for (k = 0; k < 24; k++) rq[k] = (k >= 2 && k < 2 + n) ? 8'(8'h30 + k) : 8'h00;
    rq[0] = 8'(c);
    rq[1] = 8'(n);
    rq[2] = 8'(d0);
    if (n > 1) rq[3] = 8'(d1);
    if (n > 2) rq[4] = 8'(d2);
    model();
    host_u.xfer(rq);
    chk("busy", 1, 16'(host_u.busy_ok));
    for (k = 0; k < 2 + er[1]; k++) chk("rsp", er[k], 16'(host_u.rsp_q[k]));
  endtask : cmd

  task automatic send_char(input int ch);
    int h;
    @(negedge sys_clk_i);
    for (h = 0; h < 60 && char_ready_o !== 1'b1; h++) @(negedge sys_clk_i);
    char_valid_i = 1'b1;
    char_i = ch[6:0];
    @(negedge sys_clk_i);
    char_valid_i = 1'b0;
    if (m_use[ch] == 255 && m_mod[ch] == 255)
      for (h = 100; h > 0; h /= 10) exp_q.push_back({kp((ch / h) % 10), MOD_LEFT_ALT});
    else exp_q.push_back({8'(m_use[ch]), 8'(m_mod[ch])});
  endtask : send_char

  function automatic logic [7:0] kp(input int d);
    return (d == 0) ? KP_ZERO : KP_ONE + 8'(d - 1);
  endfunction : kp

  task automatic drain();
    int k;
    for (k = 0; k < 300 && !(got_q.size() == exp_q.size() && char_ready_o === 1'b1); k++)
      @(negedge sys_clk_i);
    chk("keys", exp_q.size(), 16'(got_q.size()));
    for (k = 0; k < exp_q.size() && k < got_q.size(); k++) chk("key", exp_q[k], got_q[k]);
    exp_q.delete();
    got_q.delete();
  endtask : drain

  initial begin
    #800_000;
    failures++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h5131;
    sys_rst_i = 1'b1;
    legacy_dirty_i = 1'b0;
    char_valid_i = 1'b0;
    char_i = 7'h00;
    key_ready_i = 1'b1;
    for (i = 0; i < 128; i++) m_use[i] = 255;
    for (i = 0; i < 128; i++) m_mod[i] = 255;
    pv = '{default: 0};
    pv[2] = 1;
    repeat (6) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    chk("cfg_poll", 1, 16'(cfg_poll_o));
    cmd(3, 1, 8'h3f);
    cmd(3, 1, 8'h80);
    cmd(4, 3, 8'h90, 8'h01, 8'h01);
    cmd(4, 3, 8'h41, $random(seed) & 8'h7f, $random(seed) & 8'h0f);
    cmd(3, 1, 8'h41);
    for (i = 0; i < 12; i++) begin
      v = (i < 4) ? 8'h41 * (i & 1) + 8'h3f * (i >> 1) : $random(seed);
      send_char(v & 8'h7f);
    end
    drain();
    send_char(127);
    drain();
    for (i = 0; i < 6; i++) cmd(0, 1, (i < 3) ? i : (i == 3) ? 4 : 11 + 2 * i);
    legacy_dirty_i = 1'b1;
    n0 = reload_n;
    cmd(1, 2, 8'h02, ($random(seed) & 8'h7f) + 1);
    chk("reload", n0 + 1, 16'(reload_n));
    legacy_dirty_i = 1'b0;
    cmd(0, 1, 8'h02);
    chk("reload_idle", n0 + 1, 16'(reload_n));
    chk("cfg_hold", 1, 16'(cfg_poll_o));
    cmd(1, 4, 8'h01, 8'h4b, 8'h31);
    cmd(0, 1, 8'h01);
    cmd(1, 17, 8'h01);
    cmd(1, 3, 8'h04, 8'h80, 8'h01);
    cmd(1, 2, 8'h00, 8'h33);
    cmd(1, 2, 8'h33, 8'h01);
    cmd(0, 1, 8'h33);
    cmd(1, 2, 8'h02, 8'h00);
    cmd(1, 0, 8'h02);
    cmd(1, 2, 8'h04, 8'h80);
    cmd(1, 2, 8'h0f, 8'h01);
    cmd(1, 2, 8'h11, 8'h01);
    cmd(9, 0, 0);
    cmd(0, 23, 8'h02);
    n0 = detach_n;
    a0 = apply_n;
    cmd(2, 0, 0);
    chk("detach", n0 + DCYC, 16'(detach_n));
    chk("apply", a0 + 1, 16'(apply_n));
    chk("cfg_poll", pv[2], 16'(cfg_poll_o));
    chk("cfg_flags", pv[4], 16'(cfg_flags_o));
    chk("cfg_conv", pv[15], 16'(cfg_conv_o));
    chk("cfg_map_sel", pv[17], 16'(cfg_map_sel_o));
    cmd(3, 1, 8'h41);
    send_char(8'h41);
    drain();
    tally_and_finish();
  end
endmodule : tb
